// File: hdl/pcc_pll_clock_ctrl.sv
`timescale 1ns/1ns
module pcc_pll_clock_ctrl
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    // apb slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic [3:0]  i_pstrb,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // analog pll side
    input  wire logic        i_pll_lock_raw,
    output logic [15:0]      o_pll_denominator,
    output logic [15:0]      o_pll_numerator,
    output logic [3:0]       o_pll_multiplier,
    output logic [1:0]       o_pll_input_div,
    output logic             o_pll_fractional,
    output logic             o_pll_power_en,
    output logic             o_pll_clk_en,
    output logic             o_main_clock_enable,
    output logic             o_pulse_density_output,
    // output clock
    input  wire logic        i_mclk,
    output logic             o_output_clock_pin,
    // interrupt
    output logic             o_irq
);

    typedef struct packed
    {
        logic [7:0]  den_hi;
        logic [7:0]  den_lo;
        logic [7:0]  num_hi;
        logic [7:0]  num_lo;
        logic [6:0]  int_div;
        logic [2:0]  output_clock_rate;
        logic [3:0]  ctl;
        logic [1:0]  status;
        logic [1:0]  mask;
        logic        lock_q;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
        logic        pll_clk_en;
        logic        clk_out_en;
    } pcc_state_t;

    pcc_state_t  st_ff;
    pcc_state_t  nxt_st;
    logic        locked;
    logic [5:0]  idx;
    logic        setup;
    logic        wr_acc;
    logic        rd_acc;
    logic [1:0]  events;

    function automatic logic is_mapped(input logic [7:0] addr);
        logic [5:0] a;
        a = addr[7:2];
        is_mapped = (addr[1:0] == 2'h0) &&
                    ((a >= pcc_pkg::IDX_DEN_HIGH && a <= pcc_pkg::IDX_CLK_SEL) ||
                     a == pcc_pkg::IDX_CONTROL || a == pcc_pkg::IDX_IRQ_STATUS ||
                     a == pcc_pkg::IDX_IRQ_MASK);
    endfunction

    function automatic logic [31:0] widen(input logic [7:0] v);
        widen = {24'h000000, v};
    endfunction

    assign idx    = i_paddr[7:2];
    assign setup  = i_psel & ~i_penable;
    assign wr_acc = i_psel & i_penable & st_ff.pready & i_pwrite & is_mapped(i_paddr) & i_pstrb[0];
    assign rd_acc = i_psel & i_penable & st_ff.pready & ~i_pwrite & is_mapped(i_paddr);
    assign events = {st_ff.lock_q & ~locked, locked & ~st_ff.lock_q};

    // lock is reported only while the pll is powered
    pcc_lock_qual u_lock_qual
    (
        .i_clk      (i_clk),
        .i_reset_n  (i_reset_n),
        .i_enable   (st_ff.ctl[pcc_pkg::CTL_PLL_EN]),
        .i_lock_raw (i_pll_lock_raw),
        .o_locked   (locked)
    );

    pcc_output_clock_pin_gen u_output_clock_pin_gen
    (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_mclk    (i_mclk),
        .i_enable  (st_ff.clk_out_en),
        .i_rate    (st_ff.output_clock_rate),
        .o_pin     (o_output_clock_pin)
    );

    always_comb
    begin
        nxt_st         = st_ff;
        nxt_st.lock_q  = locked;
        nxt_st.pready  = setup;
        nxt_st.pslverr = setup & ~is_mapped(i_paddr);
        // read data are captured in setup so that the access phase needs no wait state
        if (setup)
        begin
            unique case (idx)
                pcc_pkg::IDX_DEN_HIGH:   nxt_st.prdata = widen(st_ff.den_hi);
                pcc_pkg::IDX_DEN_LOW:    nxt_st.prdata = widen(st_ff.den_lo);
                pcc_pkg::IDX_NUM_HIGH:   nxt_st.prdata = widen(st_ff.num_hi);
                pcc_pkg::IDX_NUM_LOW:    nxt_st.prdata = widen(st_ff.num_lo);
                pcc_pkg::IDX_INT_DIV:    nxt_st.prdata = widen({1'b0, st_ff.int_div});
                pcc_pkg::IDX_LOCK:       nxt_st.prdata = widen({7'h00, st_ff.lock_q});
                pcc_pkg::IDX_CLK_SEL:    nxt_st.prdata = widen({5'h00, st_ff.output_clock_rate});
                pcc_pkg::IDX_CONTROL:    nxt_st.prdata = widen({4'h0, st_ff.ctl});
                pcc_pkg::IDX_IRQ_STATUS: nxt_st.prdata = widen({6'h00, st_ff.status});
                pcc_pkg::IDX_IRQ_MASK:   nxt_st.prdata = widen({6'h00, st_ff.mask});
                default:                 nxt_st.prdata = 32'h00000000;
            endcase
        end
        // setup writes are stored even while powered; keeping the order is up to software
        if (wr_acc)
        begin
            unique case (idx)
                pcc_pkg::IDX_DEN_HIGH: nxt_st.den_hi = i_pwdata[7:0];
                pcc_pkg::IDX_DEN_LOW:  nxt_st.den_lo = i_pwdata[7:0];
                pcc_pkg::IDX_NUM_HIGH: nxt_st.num_hi = i_pwdata[7:0];
                pcc_pkg::IDX_NUM_LOW:  nxt_st.num_lo = i_pwdata[7:0];
                pcc_pkg::IDX_INT_DIV:
                    nxt_st.int_div = i_pwdata[6:0] & pcc_pkg::INT_DIV_MASK[6:0];
                pcc_pkg::IDX_CLK_SEL:
                    nxt_st.output_clock_rate = i_pwdata[2:0] & pcc_pkg::RATE_MASK[2:0];
                pcc_pkg::IDX_CONTROL:  nxt_st.ctl = i_pwdata[3:0] & pcc_pkg::CTL_MASK[3:0];
                pcc_pkg::IDX_IRQ_MASK: nxt_st.mask = i_pwdata[1:0] & pcc_pkg::IRQ_MASK[1:0];
                // lock and status ignore writes
                default:               nxt_st.ctl = st_ff.ctl;
            endcase
        end
        // only bits that were reported are cleared, and a new event wins over the clear
        nxt_st.status = st_ff.status;
        if (rd_acc && idx == pcc_pkg::IDX_IRQ_STATUS)
        begin
            nxt_st.status = st_ff.status & ~st_ff.prdata[1:0];
        end
        nxt_st.status = nxt_st.status | events;
        nxt_st.irq    = |(nxt_st.status & nxt_st.mask);
        nxt_st.pll_clk_en = nxt_st.ctl[pcc_pkg::CTL_PLL_EN] &
                            nxt_st.ctl[pcc_pkg::CTL_MAIN_EN];
        // the two fastest rates are dropped while pulse-density output runs
        nxt_st.clk_out_en = nxt_st.ctl[pcc_pkg::CTL_PIN_CLK] &
                            ~(nxt_st.ctl[pcc_pkg::CTL_PDM_EN] &
                              (nxt_st.output_clock_rate == pcc_pkg::RATE_X2 ||
                               nxt_st.output_clock_rate == pcc_pkg::RATE_X1));
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign o_prdata               = st_ff.prdata;
    assign o_pready               = st_ff.pready;
    assign o_pslverr              = st_ff.pslverr;
    assign o_irq                  = st_ff.irq;
    assign o_pll_denominator      = {st_ff.den_hi, st_ff.den_lo};
    assign o_pll_numerator        = {st_ff.num_hi, st_ff.num_lo};
    assign o_pll_multiplier       = st_ff.int_div[pcc_pkg::MULT_MSB:pcc_pkg::MULT_LSB];
    assign o_pll_input_div        = st_ff.int_div[pcc_pkg::DIV_MSB:pcc_pkg::DIV_LSB];
    assign o_pll_fractional       = st_ff.int_div[pcc_pkg::TYPE_BIT];
    assign o_pll_power_en         = st_ff.ctl[pcc_pkg::CTL_PLL_EN];
    assign o_pll_clk_en           = st_ff.pll_clk_en;
    assign o_main_clock_enable    = st_ff.ctl[pcc_pkg::CTL_MAIN_EN];
    assign o_pulse_density_output = st_ff.ctl[pcc_pkg::CTL_PDM_EN];

    property p_den_store;
        @(posedge i_clk) disable iff (!i_reset_n)
        (wr_acc && idx == pcc_pkg::IDX_DEN_HIGH) |=>
            (o_pll_denominator[15:8] == $past(i_pwdata[7:0]));
    endproperty
    a_den_store: assert property (p_den_store)
        else $error("denominator high byte not stored");

    property p_num_store;
        @(posedge i_clk) disable iff (!i_reset_n)
        (wr_acc && idx == pcc_pkg::IDX_NUM_LOW) |=> (o_pll_numerator[7:0] == $past(i_pwdata[7:0]));
    endproperty
    a_num_store: assert property (p_num_store)
        else $error("numerator low byte not stored");

    property p_mult_store;
        @(posedge i_clk) disable iff (!i_reset_n)
        (wr_acc && idx == pcc_pkg::IDX_INT_DIV) |=>
            (o_pll_multiplier == $past(i_pwdata[6:3]) && o_pll_fractional == $past(i_pwdata[0]));
    endproperty
    a_mult_store: assert property (p_mult_store)
        else $error("multiplier or mode not stored");

    property p_div_store;
        @(posedge i_clk) disable iff (!i_reset_n)
        (wr_acc && idx == pcc_pkg::IDX_INT_DIV) |=> (o_pll_input_div == $past(i_pwdata[2:1]));
    endproperty
    a_div_store: assert property (p_div_store)
        else $error("input divider not stored");

    property p_lock_read;
        @(posedge i_clk) disable iff (!i_reset_n)
        (setup && !i_pwrite && idx == pcc_pkg::IDX_LOCK && i_paddr[1:0] == 2'h0) |=>
            (o_pready && o_prdata == {31'h00000000, $past(st_ff.lock_q)});
    endproperty
    a_lock_read: assert property (p_lock_read)
        else $error("lock read data wrong");

    property p_reserved_zero;
        @(posedge i_clk) disable iff (!i_reset_n)
        (o_pready && !i_pwrite && idx == pcc_pkg::IDX_INT_DIV) |-> (o_prdata[31:7] == 25'h0000000);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read nonzero");

    property p_power_off;
        @(posedge i_clk) disable iff (!i_reset_n)
        $fell(o_pll_power_en) |-> (!o_pll_clk_en ##1 !o_pll_clk_en ##1 !st_ff.lock_q);
    endproperty
    a_power_off: assert property (p_power_off)
        else $error("pll clock or lock remained after power off");

    property p_rate_off;
        @(posedge i_clk) disable iff (!i_reset_n)
        (st_ff.output_clock_rate == pcc_pkg::RATE_OFF)[*3] |-> !o_output_clock_pin;
    endproperty
    a_rate_off: assert property (p_rate_off)
        else $error("output clock not low when off");

    property p_pin_mode;
        @(posedge i_clk) disable iff (!i_reset_n)
        (!st_ff.ctl[pcc_pkg::CTL_PIN_CLK])[*3] |-> !o_output_clock_pin;
    endproperty
    a_pin_mode: assert property (p_pin_mode)
        else $error("output clock active outside clock mode");

    property p_pdm_fast;
        @(posedge i_clk) disable iff (!i_reset_n)
        (o_pulse_density_output && st_ff.output_clock_rate <= pcc_pkg::RATE_X1)[*3]
            |-> !o_output_clock_pin;
    endproperty
    a_pdm_fast: assert property (p_pdm_fast)
        else $error("fast rate produced with pulse-density output");

    property p_irq_level;
        @(posedge i_clk) disable iff (!i_reset_n)
        $rose(locked) |=>
            (st_ff.status[pcc_pkg::IRQ_LOCK_UP] && (o_irq == st_ff.mask[0] || st_ff.mask[1]));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("lock event not recorded");

    property p_den_low_store;
        @(posedge i_clk) disable iff (!i_reset_n)
        (wr_acc && idx == pcc_pkg::IDX_DEN_LOW) |=>
            (o_pll_denominator[7:0] == $past(i_pwdata[7:0]));
    endproperty
    a_den_low_store: assert property (p_den_low_store)
        else $error("denominator low byte not stored");

    property p_num_high_store;
        @(posedge i_clk) disable iff (!i_reset_n)
        (wr_acc && idx == pcc_pkg::IDX_NUM_HIGH) |=>
            (o_pll_numerator[15:8] == $past(i_pwdata[7:0]));
    endproperty
    a_num_high_store: assert property (p_num_high_store)
        else $error("numerator high byte not stored");

    property p_rate_store;
        @(posedge i_clk) disable iff (!i_reset_n)
        (wr_acc && idx == pcc_pkg::IDX_CLK_SEL) |=>
            (st_ff.output_clock_rate == $past(i_pwdata[2:0]));
    endproperty
    a_rate_store: assert property (p_rate_store)
        else $error("rate code not stored");

    property p_lock_needs_power;
        @(posedge i_clk) disable iff (!i_reset_n)
        !o_pll_power_en |=> !locked;
    endproperty
    a_lock_needs_power: assert property (p_lock_needs_power)
        else $error("lock reported while pll unpowered");

    property p_pll_clk_gate;
        @(posedge i_clk) disable iff (!i_reset_n)
        o_pll_clk_en == (o_pll_power_en && o_main_clock_enable);
    endproperty
    a_pll_clk_gate: assert property (p_pll_clk_gate)
        else $error("pll clock enable does not match power and main enable");

    property p_x1_follow;
        @(posedge i_clk) disable iff (!i_reset_n)
        (st_ff.clk_out_en && st_ff.output_clock_rate == pcc_pkg::RATE_X1) |=>
            (o_output_clock_pin == $past(i_mclk));
    endproperty
    a_x1_follow: assert property (p_x1_follow)
        else $error("output clock does not follow master clock");

    property p_slverr;
        @(posedge i_clk) disable iff (!i_reset_n)
        (setup && !is_mapped(i_paddr)) |=>
            (o_pready && o_pslverr);
    endproperty
    a_slverr: assert property (p_slverr)
        else $error("unmapped access not refused");

    property p_undef_read;
        @(posedge i_clk) disable iff (!i_reset_n)
        (o_pready && !i_pwrite) |-> (o_prdata[31:8] == 24'h000000);
    endproperty
    a_undef_read: assert property (p_undef_read)
        else $error("undefined read bits nonzero");

    property p_pready_pulse;
        @(posedge i_clk) disable iff (!i_reset_n)
        o_pready |=> !o_pready;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse)
        else $error("ready held longer than one cycle");

    property p_irq_masked;
        @(posedge i_clk) disable iff (!i_reset_n)
        o_irq == (|(st_ff.status & st_ff.mask));
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("interrupt level does not match masked status");

endmodule

// File: hdl/pcc_pkg.sv
package pcc_pkg;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_DEN_HIGH   = 6'h01;
    localparam logic [5:0] IDX_DEN_LOW    = 6'h02;
    localparam logic [5:0] IDX_NUM_HIGH   = 6'h03;
    localparam logic [5:0] IDX_NUM_LOW    = 6'h04;
    localparam logic [5:0] IDX_INT_DIV    = 6'h05;
    localparam logic [5:0] IDX_LOCK       = 6'h06;
    localparam logic [5:0] IDX_CLK_SEL    = 6'h07;
    localparam logic [5:0] IDX_CONTROL    = 6'h10;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h11;
    localparam logic [5:0] IDX_IRQ_MASK   = 6'h12;

    // reset value and writable bits of each register
    localparam logic [7:0] REG_RESET      = 8'h00;
    localparam logic [7:0] INT_DIV_MASK   = 8'h7f;
    localparam logic [7:0] RATE_MASK      = 8'h07;
    localparam logic [7:0] CTL_MASK       = 8'h0f;
    localparam logic [7:0] IRQ_MASK       = 8'h03;

    // field positions
    localparam int MULT_LSB      = 3;
    localparam int MULT_MSB      = 6;
    localparam int DIV_LSB       = 1;
    localparam int DIV_MSB       = 2;
    localparam int TYPE_BIT      = 0;
    localparam int LOCK_BIT      = 0;
    localparam int CTL_PLL_EN    = 0;
    localparam int CTL_MAIN_EN   = 1;
    localparam int CTL_PIN_CLK   = 2;
    localparam int CTL_PDM_EN    = 3;
    localparam int IRQ_LOCK_UP   = 0;
    localparam int IRQ_LOCK_DOWN = 1;

    // output clock rate codes
    localparam logic [2:0] RATE_X2   = 3'h0;
    localparam logic [2:0] RATE_X1   = 3'h1;
    localparam logic [2:0] RATE_DIV2 = 3'h2;
    localparam logic [2:0] RATE_DIV4 = 3'h3;
    localparam logic [2:0] RATE_DIV8 = 3'h4;
    localparam logic [2:0] RATE_OFF  = 3'h7;

    // timing
    localparam int CLK_PERIOD_NS  = 8;
    localparam int CLK_HZ         = 125000000;
    localparam int MCLK_HZ        = 12288000;
    localparam int X2_HIGH_CYC    = (CLK_HZ / (4 * MCLK_HZ)) < 1 ? 1 : CLK_HZ / (4 * MCLK_HZ);
    localparam int LOCK_QUAL_NS   = 1000;
    localparam int LOCK_QUAL_CYC  = (LOCK_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] X2_HIGH_LOAD   = 2'(X2_HIGH_CYC - 1);
    localparam logic [7:0] LOCK_QUAL_LOAD = 8'(LOCK_QUAL_CYC - 1);

endpackage

// File: hdl/pcc_lock_qual.sv
`timescale 1ns/1ns
module pcc_lock_qual
(
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    // control and raw lock
    input  wire logic i_enable,
    input  wire logic i_lock_raw,
    // qualified lock
    output logic      o_locked
);

    typedef struct packed
    {
        logic [7:0] cnt;
        logic       locked;
    } pcc_lq_state_t;

    pcc_lq_state_t st_ff;
    pcc_lq_state_t nxt_st;

    // lock must hold steadily before it is reported, so a glitching detector cannot flap the flag
    always_comb
    begin
        nxt_st = st_ff;
        if (!i_enable || !i_lock_raw)
        begin
            nxt_st.cnt    = pcc_pkg::LOCK_QUAL_LOAD;
            nxt_st.locked = 1'b0;
        end
        else if (st_ff.cnt != 8'h00)
        begin
            nxt_st.cnt = st_ff.cnt - 8'h01;
        end
        else
        begin
            nxt_st.locked = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            st_ff <= '{cnt: pcc_pkg::LOCK_QUAL_LOAD, locked: 1'b0};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign o_locked = st_ff.locked;

endmodule

// File: hdl/pcc_output_clock_pin_gen.sv
`timescale 1ns/1ns
module pcc_output_clock_pin_gen
(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_reset_n,
    // master clock level, sampled on i_clk
    input  wire logic       i_mclk,
    // control
    input  wire logic       i_enable,
    input  wire logic [2:0] i_rate,
    // pin
    output logic            o_pin
);

    typedef struct packed
    {
        logic       mclk_q;
        logic [1:0] div_cnt;
        logic [1:0] pulse_cnt;
        logic       tog;
        logic       pin;
    } pcc_cg_state_t;

    pcc_cg_state_t st_ff;
    pcc_cg_state_t nxt_st;
    logic          rise;
    logic          edge_any;

    function automatic logic due(input logic [1:0] cnt, input logic [1:0] need);
        due = ((cnt & need) == need);
    endfunction

    assign rise     = i_mclk & ~st_ff.mclk_q;
    assign edge_any = i_mclk ^ st_ff.mclk_q;

    // the doubled rate is a short pulse on each master edge; duty is not 50 percent
    always_comb
    begin
        nxt_st        = st_ff;
        nxt_st.mclk_q = i_mclk;
        if (rise)
        begin
            nxt_st.div_cnt = st_ff.div_cnt + 2'h1;
        end
        if (!i_enable)
        begin
            nxt_st.div_cnt   = 2'h0;
            nxt_st.pulse_cnt = 2'h0;
            nxt_st.tog       = 1'b0;
            nxt_st.pin       = 1'b0;
        end
        else
        begin
            unique case (i_rate)
                pcc_pkg::RATE_X2:
                begin
                    nxt_st.pulse_cnt = edge_any ? pcc_pkg::X2_HIGH_LOAD :
                                       (st_ff.pulse_cnt != 2'h0) ? st_ff.pulse_cnt - 2'h1 : 2'h0;
                    nxt_st.pin       = edge_any | (st_ff.pulse_cnt != 2'h0);
                end
                pcc_pkg::RATE_X1:
                begin
                    nxt_st.pin = i_mclk;
                end
                pcc_pkg::RATE_DIV2, pcc_pkg::RATE_DIV4, pcc_pkg::RATE_DIV8:
                begin
                    if (rise && due(st_ff.div_cnt, (i_rate == pcc_pkg::RATE_DIV2) ? 2'h0 :
                                    (i_rate == pcc_pkg::RATE_DIV4) ? 2'h1 : 2'h3))
                    begin
                        nxt_st.tog = ~st_ff.tog;
                    end
                    nxt_st.pin = nxt_st.tog;
                end
                default:
                begin
                    nxt_st.tog = 1'b0;
                    nxt_st.pin = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign o_pin = st_ff.pin;

endmodule

// File: verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    typedef struct {logic rd; logic err; logic [31:0] data;} pcc_tb_note_t;
    // clock, reset and apb
    logic        i_clk;
    logic        i_reset_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    // pll side and output clock
    logic        lock_raw;
    logic        mclk;
    logic        mclk_run;
    logic [15:0] den;
    logic [15:0] num;
    logic [3:0]  mult;
    logic [1:0]  idiv;
    logic        frac;
    logic        pwr;
    logic        clk_en;
    logic        main_en;
    logic        pdm;
    logic        pin;
    logic        irq;
    // bench state
    pcc_tb_note_t notes[$];
    pcc_tb_note_t cur;
    int          bad_count;
    int          n_tests;
    int          mdiv;
    int          cnt;
    logic [7:0]  d [8];
    logic [7:0]  wmask [8];

    pcc_pll_clock_ctrl i_dut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_pll_lock_raw(lock_raw), .o_pll_denominator(den), .o_pll_numerator(num),
        .o_pll_multiplier(mult), .o_pll_input_div(idiv), .o_pll_fractional(frac),
        .o_pll_power_en(pwr), .o_pll_clk_en(clk_en), .o_main_clock_enable(main_en),
        .o_pulse_density_output(pdm), .i_mclk(mclk), .o_output_clock_pin(pin), .o_irq(irq)
    );

    initial i_clk = 1'b0;
    always #4 i_clk = ~i_clk;

    // master clock near 12.5 MHz, made on i_clk so that it is a clean synchronous level
    always @(posedge i_clk)
    begin
        if (mdiv == 4)
        begin
            mdiv <= 0;
            mclk <= mclk_run ? ~mclk : mclk;
        end
        else
            mdiv <= mdiv + 1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // one apb transfer, then one idle cycle so no signal is assigned twice in a step
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
                       input logic [31:0] exp, input logic err);
        int n;
        notes.push_back('{rd: !wr, err: err, data: exp});
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge i_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            bad_count++;
            final_report();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge i_clk);
    endtask

    // the monitor pairs each answer with the oldest note of the driver
    always @(posedge i_clk)
    begin
        if (psel && penable && pready === 1'b1)
        begin
            cur = notes.pop_front();
            check(32'(pslverr), 32'(cur.err));
            if (cur.rd)
                check(prdata, cur.data);
        end
    end

    task automatic count_rises(output int c);
        logic prev;
        c = 0;
        prev = pin;
        repeat (400)
        begin
            @(posedge i_clk);
            #1;
            if (pin === 1'b1 && prev === 1'b0)
                c++;
            prev = pin;
        end
    endtask

    // control value, rate code, expected rising edges in 400 cycles, master clock running
    int cases [12][4] = '{'{4, 0, 80, 1}, '{4, 1, 40, 1}, '{4, 2, 20, 1}, '{4, 3, 10, 1},
                          '{4, 4, 5, 1}, '{4, 7, 0, 1}, '{4, 5, 0, 1}, '{0, 1, 0, 1},
                          '{12, 0, 0, 1}, '{12, 1, 0, 1}, '{12, 2, 20, 1}, '{4, 1, 0, 0}};

    initial
    begin
        void'($urandom(49));
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {lock_raw, mclk, mdiv} = '0;
        mclk_run = 1'b1;
        wmask = '{8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'h7f, 8'h00, 8'h07};
        i_reset_n = 1'b0;
        repeat (3) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(posedge i_clk);
        for (int i = 1; i < 8; i++)
            apb(1'b0, 6'(i), '0, 32'h0, 1'b0);
        for (int i = 1; i < 8; i++)
        begin
            d[i] = 8'($urandom());
            apb(1'b1, 6'(i), {24'($urandom()), d[i]}, '0, 1'b0);
            apb(1'b0, 6'(i), '0, {24'h0, d[i] & wmask[i]}, 1'b0);
        end
        check({16'h0, den}, {16'h0, d[1], d[2]});
        check({16'h0, num}, {16'h0, d[3], d[4]});
        check({mult, idiv, frac}, {d[5][6:3], d[5][2:1], d[5][0]});
        apb(1'b0, 6'h00, '0, 32'h0, 1'b1);
        apb(1'b1, 6'h20, 32'hff, '0, 1'b1);
        // lock flag and its interrupt
        apb(1'b1, pcc_pkg::IDX_IRQ_MASK, 32'h3, '0, 1'b0);
        apb(1'b1, pcc_pkg::IDX_CONTROL, 32'h1, '0, 1'b0);
        lock_raw <= 1'b1;
        apb(1'b0, pcc_pkg::IDX_LOCK, '0, 32'h0, 1'b0);
        cnt = 0;
        while (irq !== 1'b1 && cnt < 300)
        begin
            @(posedge i_clk);
            cnt++;
        end
        if (cnt >= 300)
        begin
            bad_count++;
            final_report();
        end
        check(32'(irq), 32'h1);
        apb(1'b0, pcc_pkg::IDX_LOCK, '0, 32'h1, 1'b0);
        apb(1'b1, pcc_pkg::IDX_LOCK, 32'h0, '0, 1'b0);
        apb(1'b0, pcc_pkg::IDX_LOCK, '0, 32'h1, 1'b0);
        apb(1'b0, pcc_pkg::IDX_IRQ_STATUS, '0, 32'h1, 1'b0);
        #1;
        check(32'(irq), 32'h0);
        check(32'(clk_en), 32'h0);
        apb(1'b1, pcc_pkg::IDX_CONTROL, 32'h3, '0, 1'b0);
        repeat (2) @(posedge i_clk);
        #1;
        check({pwr, main_en, clk_en}, 3'b111);
        // masked lock loss must not raise the interrupt
        apb(1'b1, pcc_pkg::IDX_IRQ_MASK, 32'h1, '0, 1'b0);
        lock_raw <= 1'b0;
        repeat (10) @(posedge i_clk);
        #1;
        check(32'(irq), 32'h0);
        apb(1'b0, pcc_pkg::IDX_LOCK, '0, 32'h0, 1'b0);
        apb(1'b0, pcc_pkg::IDX_IRQ_STATUS, '0, 32'h2, 1'b0);
        apb(1'b0, pcc_pkg::IDX_IRQ_STATUS, '0, 32'h0, 1'b0);
        apb(1'b1, pcc_pkg::IDX_CONTROL, 32'h2, '0, 1'b0);
        repeat (2) @(posedge i_clk);
        #1;
        check(32'(clk_en), 32'h0);
        // output clock rates, pin mode, pulse-density limit and master clock dependence
        for (int i = 0; i < 12; i++)
        begin
            mclk_run <= cases[i][3][0];
            apb(1'b1, pcc_pkg::IDX_CONTROL, 32'(cases[i][0]), '0, 1'b0);
            apb(1'b1, pcc_pkg::IDX_CLK_SEL, 32'(cases[i][1]), '0, 1'b0);
            repeat (20) @(posedge i_clk);
            count_rises(cnt);
            check(32'(cnt >= cases[i][2] - 1 && cnt <= cases[i][2] + 1),
                  32'h1);
            check(32'(pdm), 32'(cases[i][0] >= 8));
        end
        final_report();
    end
endmodule
